// ===== hw/opmode_pkg.sv
/*
  constants, state codes and the control carrier for the operating-mode
  controller; assumes a 250 MHz core clock and a 32-bit wishbone slave port
*/
package opmode_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTL_ONE = 8'h00; // system_control_one
  localparam logic [7:0] ADDR_CTL_TWO = 8'h04; // system_control_two
  localparam logic [7:0] ADDR_TBC     = 8'h08; // time_base_control
  localparam logic [7:0] ADDR_IRQ     = 8'h0c; // interrupt enables
  localparam logic [7:0] ADDR_STAT    = 8'h10; // mode status, read only

  // system_control_one fields
  localparam int C1_STOP    = 0;
  localparam int C1_REL_LVL = 1;
  localparam int C1_RET_SLW = 2;
  localparam logic [2:0] C1_RST = 3'h0;

  // system_control_two fields
  localparam int C2_DOZE  = 0;
  localparam int C2_PGATE = 1;
  localparam int C2_MCLK  = 2;
  localparam int C2_SLOW  = 3;
  localparam int C2_FAST  = 4;
  localparam logic [4:0] C2_RST = 5'h10;

  // time_base_control fields
  localparam int TB_SEL_LO = 0;
  localparam int TB_EN     = 3;
  localparam logic [3:0] TB_RST = 4'h0;

  // interrupt enable fields
  localparam int IR_MIE  = 0;
  localparam int IR_TBIE = 1;
  localparam logic [1:0] IR_RST = 2'h0;

  // timing
  localparam int CLK_NS  = 4;
  localparam int WARM_NS = 32768;
  localparam int WARM_CYC = (WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] MC_LAST = 2'h3; // four clocks per machine cycle

  typedef enum logic [3:0] {
    run_fast_single  = 4'h0,
    doze_fast_single = 4'h1,
    deep_doze_fast   = 4'h3,
    run_fast_dual    = 4'h2,
    doze_fast_dual   = 4'h6,
    run_slow_dual    = 4'h7,
    doze_slow_dual   = 4'h5,
    run_slow_only    = 4'h4,
    doze_slow_only   = 4'hc,
    deep_doze_slow   = 4'hd,
    oscillator_off_state = 4'hf
  } mode_t;

  typedef struct packed {
    logic fast_osc_on;
    logic slow_osc_on;
    logic main_clk_slow;
    logic cpu_run;
    logic wdt_run;
    logic periph_clk_on;
    logic tbt_clk_on;
    logic div_low_on;
    logic slow_pins_osc;
  } pwr_ctl_t;

endpackage

// ===== hw/operating_mode_controller.sv
/*
  operating-mode controller: run, doze, deep-doze and oscillator-off
  states, oscillator and clock gating, wake events; assumes a classic
  wishbone master on core_clk and inputs synchronous to core_clk
*/
`timescale 1ns/1ns
module operating_mode_controller import opmode_pkg::*; #(
  parameter int WARM_COUNT = WARM_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  input  wire logic        irq_req,
  input  wire logic [7:0]  tb_src,
  input  wire logic        halt_release,
  output pwr_ctl_t         pwr,
  output logic             take_irq,
  output logic             resume_next,
  output logic             tbt_irq_set,
  output logic             self_reset,
  output logic             machine_tick
);

  mode_t       state_q;
  mode_t       state_d;
  pwr_ctl_t    pwr_q;
  logic [2:0]  c1_q;
  logic [4:0]  c2_q;
  logic [3:0]  tbc_q;
  logic [1:0]  ir_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        tb_prev_q;
  logic        tbe_entry_q;
  logic        rel_prev_q;
  logic        rel_seen_q;
  logic [15:0] warm_q;
  logic [1:0]  mc_q;
  logic        take_q;
  logic        resume_q;
  logic        tbset_q;
  logic        srst_q;
  logic        req;
  logic        wr;
  logic        wr2;
  logic [4:0]  w2;
  logic        bad;
  logic        tb_fall;
  logic        doze_wake;
  logic        deep_wake;
  logic        warm_done;
  logic        tick_q;
  function automatic mode_t run_of(input logic [4:0] c);
    if (c[C2_MCLK]) begin
      run_of = c[C2_FAST] ? run_slow_dual : run_slow_only;
    end else begin
      run_of = c[C2_SLOW] ? run_fast_dual : run_fast_single;
    end
  endfunction
  function automatic pwr_ctl_t ctl_of(input mode_t s);
    pwr_ctl_t p;
    p = '0;
    p.fast_osc_on = 1'b1;
    p.cpu_run = 1'b1;
    p.wdt_run = 1'b1;
    p.periph_clk_on = 1'b1;
    p.tbt_clk_on = 1'b1;
    p.div_low_on = 1'b1;
    case (s)
      run_fast_single: begin
      end
      doze_fast_single: begin
        p.cpu_run = 1'b0;
        p.wdt_run = 1'b0;
      end
      deep_doze_fast: begin
        p.cpu_run = 1'b0;
        p.wdt_run = 1'b0;
        p.periph_clk_on = 1'b0;
      end
      run_fast_dual: begin
        p.slow_osc_on = 1'b1;
      end
      doze_fast_dual: begin
        p.slow_osc_on = 1'b1;
        p.cpu_run = 1'b0;
        p.wdt_run = 1'b0;
      end
      run_slow_dual: begin
        p.slow_osc_on = 1'b1;
        p.main_clk_slow = 1'b1;
        p.div_low_on = 1'b0;
      end
      doze_slow_dual: begin
        p.slow_osc_on = 1'b1;
        p.main_clk_slow = 1'b1;
        p.div_low_on = 1'b0;
        p.cpu_run = 1'b0;
        p.wdt_run = 1'b0;
      end
      run_slow_only: begin
        p.fast_osc_on = 1'b0;
        p.slow_osc_on = 1'b1;
        p.main_clk_slow = 1'b1;
        p.div_low_on = 1'b0;
      end
      doze_slow_only, deep_doze_slow: begin
        p.fast_osc_on = 1'b0;
        p.slow_osc_on = 1'b1;
        p.main_clk_slow = 1'b1;
        p.div_low_on = 1'b0;
        p.cpu_run = 1'b0;
        p.wdt_run = 1'b0;
        p.periph_clk_on = (s == doze_slow_only);
      end
      default: begin
        p = '0;
      end
    endcase
    p.slow_pins_osc = p.slow_osc_on;
    ctl_of = p;
  endfunction
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wr2 = wr & (wb_adr_i == ADDR_CTL_TWO);
  assign w2 = wb_dat_i[4:0];
  assign bad = wr2 & ((~w2[C2_FAST] & ~(w2[C2_SLOW] & w2[C2_MCLK])) |
               (~w2[C2_SLOW] & w2[C2_MCLK]));
  assign tb_fall = tb_prev_q & ~tb_src[tbc_q[TB_SEL_LO +: 3]];
  assign doze_wake = irq_req & (state_q inside {doze_fast_single,
                     doze_fast_dual, doze_slow_dual, doze_slow_only});
  assign deep_wake = tb_fall & ((state_q == deep_doze_fast) |
                     (state_q == deep_doze_slow));
  assign warm_done = rel_seen_q & (warm_q == 16'(WARM_COUNT - 1));
  always_comb begin
    state_d = state_q;
    case (state_q)
      run_fast_single, run_fast_dual, run_slow_dual, run_slow_only: begin
        if (wr && wb_adr_i == ADDR_CTL_ONE && wb_dat_i[C1_STOP]) begin
          state_d = oscillator_off_state;
        end else if (wr2 && w2[C2_PGATE]) begin
          state_d = c2_q[C2_MCLK] ? deep_doze_slow : deep_doze_fast;
        end else if (wr2 && w2[C2_DOZE]) begin
          case (state_q)
            run_fast_single: state_d = doze_fast_single;
            run_fast_dual:   state_d = doze_fast_dual;
            run_slow_dual:   state_d = doze_slow_dual;
            default:         state_d = doze_slow_only;
          endcase
        end else if (wr2) begin
          state_d = run_of(w2);
        end
      end
      doze_fast_single: if (irq_req) state_d = run_fast_single;
      doze_fast_dual:   if (irq_req) state_d = run_fast_dual;
      doze_slow_dual:   if (irq_req) state_d = run_slow_dual;
      doze_slow_only:   if (irq_req) state_d = run_slow_only;
      deep_doze_fast:   if (tb_fall) state_d = run_fast_single;
      deep_doze_slow:   if (tb_fall) state_d = run_slow_only;
      oscillator_off_state: begin
        if (warm_done) begin
          state_d = c1_q[C1_RET_SLW] ? run_slow_only : run_fast_single;
        end
      end
      default: state_d = run_fast_single;
    endcase
    if (bad) begin
      state_d = run_fast_single;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= run_fast_single;
      pwr_q <= ctl_of(run_fast_single);
    end else if (clk_en) begin
      state_q <= state_d;
      pwr_q <= ctl_of(state_d);
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      c1_q <= C1_RST;
      c2_q <= C2_RST;
      tbc_q <= TB_RST;
      ir_q <= IR_RST;
    end else if (clk_en) begin
      if (bad) begin
        c1_q <= C1_RST;
        c2_q <= C2_RST;
        tbc_q <= TB_RST;
        ir_q <= IR_RST;
      end else begin
        if (wr && wb_adr_i == ADDR_CTL_ONE) c1_q <= wb_dat_i[2:0];
        if (wr2) c2_q <= w2;
        if (wr && wb_adr_i == ADDR_TBC) tbc_q <= wb_dat_i[3:0];
        if (wr && wb_adr_i == ADDR_IRQ) ir_q <= wb_dat_i[1:0];
        if (doze_wake) c2_q[C2_DOZE] <= 1'b0;
        if (deep_wake) c2_q[C2_PGATE] <= 1'b0;
        if (deep_wake && state_q == deep_doze_slow) begin
          c2_q[C2_FAST] <= 1'b0;
        end
        if (warm_done) begin
          c1_q[C1_STOP] <= 1'b0;
          c2_q[C2_MCLK] <= c1_q[C1_RET_SLW];
          c2_q[C2_FAST] <= ~c1_q[C1_RET_SLW];
          if (c1_q[C1_RET_SLW]) c2_q[C2_SLOW] <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tb_prev_q <= 1'b0;
      tbe_entry_q <= 1'b0;
    end else if (clk_en) begin
      tb_prev_q <= tb_src[tbc_q[TB_SEL_LO +: 3]];
      if (state_d != state_q && (state_d == deep_doze_fast ||
          state_d == deep_doze_slow)) begin
        tbe_entry_q <= tbc_q[TB_EN];
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rel_prev_q <= 1'b0;
      rel_seen_q <= 1'b0;
      warm_q <= 16'h0000;
    end else if (clk_en) begin
      rel_prev_q <= halt_release;
      if (state_q != oscillator_off_state || warm_done) begin
        rel_seen_q <= 1'b0;
        warm_q <= 16'h0000;
      end else if (rel_seen_q) begin
        warm_q <= warm_q + 16'h0001;
      end else if (c1_q[C1_REL_LVL] ? halt_release
                   : (halt_release & ~rel_prev_q)) begin
        rel_seen_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      take_q <= 1'b0;
      resume_q <= 1'b0;
      tbset_q <= 1'b0;
      srst_q <= 1'b0;
    end else if (clk_en) begin
      take_q <= 1'b0;
      resume_q <= 1'b0;
      tbset_q <= 1'b0;
      srst_q <= bad;
      if (doze_wake) begin
        take_q <= ir_q[IR_MIE];
        resume_q <= ~ir_q[IR_MIE];
      end
      if (deep_wake) begin
        take_q <= ir_q[IR_MIE] & ir_q[IR_TBIE] & tbc_q[TB_EN];
        resume_q <= ~(ir_q[IR_MIE] & ir_q[IR_TBIE] & tbc_q[TB_EN]);
        tbset_q <= tbe_entry_q;
      end
      if (warm_done) resume_q <= 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mc_q <= 2'h0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      tick_q <= (mc_q == MC_LAST) & pwr_q.cpu_run;
      if (pwr_q.cpu_run) mc_q <= mc_q + 2'h1;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_q <= req;
      if (req) begin
        case (wb_adr_i)
          ADDR_CTL_ONE: dat_q <= {29'h0, c1_q};
          ADDR_CTL_TWO: dat_q <= {27'h0, c2_q};
          ADDR_TBC:     dat_q <= {28'h0, tbc_q};
          ADDR_IRQ:     dat_q <= {30'h0, ir_q};
          ADDR_STAT:    dat_q <= {28'h0, state_q};
          default:      dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pwr = pwr_q;
  assign take_irq = take_q;
  assign resume_next = resume_q;
  assign tbt_irq_set = tbset_q;
  assign self_reset = srst_q;
  assign machine_tick = tick_q;

  a_doze_wake_run: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && state_q == doze_fast_single && irq_req
    |=> state_q == run_fast_single) else $error("doze did not wake");
  a_doze_cpu_halt: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == doze_fast_single |-> !pwr.cpu_run && !pwr.wdt_run &&
    pwr.periph_clk_on) else $error("doze gating wrong");
  a_wake_irq_taken: assert property (@(posedge core_clk)
    disable iff (!resetn) clk_en && doze_wake && ir_q[IR_MIE]
    |=> take_irq && !resume_next) else $error("irq not taken");
  a_wake_resume_next: assert property (@(posedge core_clk)
    disable iff (!resetn) clk_en && doze_wake && !ir_q[IR_MIE]
    |=> resume_next && !take_irq) else $error("no resume");
  a_deep_gate_only: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == deep_doze_fast |-> !pwr.periph_clk_on && pwr.tbt_clk_on)
    else $error("deep doze gating wrong");
  a_tb_latch_set: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && deep_wake && tbe_entry_q |=> tbt_irq_set)
    else $error("timer latch not set");
  a_bad_osc_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && bad |=> self_reset && state_q == run_fast_single &&
    c2_q == C2_RST) else $error("no self reset");
  a_doze_bit_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && doze_wake && !bad |=> !c2_q[C2_DOZE])
    else $error("doze bit stuck");
  a_gate_bit_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && deep_wake && !bad |=> !c2_q[C2_PGATE])
    else $error("gate bit stuck");
  a_slow_div_stop: assert property (@(posedge core_clk) disable iff (!resetn)
    pwr.main_clk_slow |-> !pwr.div_low_on && pwr.slow_osc_on)
    else $error("low divider running");
  a_osc_off_all: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == oscillator_off_state |-> !pwr.fast_osc_on &&
    !pwr.slow_osc_on && !pwr.cpu_run) else $error("oscillator on");
endmodule

// ===== dv/testbench.sv
/*
  self-checking bench for the operating-mode controller: wishbone
  register tasks, mode walks, wake events and pulse counts; assumes
  the design package and a short warm-up count of 8 cycles
*/
`timescale 1ns/1ns
module testbench import opmode_pkg::*;;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        irq_req = 1'b0;
  logic [7:0]  tb_src = 8'hff;
  logic        halt_release = 1'b0;
  pwr_ctl_t    pwr;
  logic        take_irq;
  logic        resume_next;
  logic        tbt_irq_set;
  logic        self_reset;
  logic        machine_tick;
  int          num_errors = 0;
  int          comparisons = 0;
  int          n_take = 0;
  int          n_res = 0;
  int          n_tbt = 0;
  int          n_rst = 0;
  int          n_tick = 0;
  int          t0;
  logic [7:0]  pre_v [3] = '{8'h18, 8'h1c, 8'h18};
  logic [7:0]  bad_v [3] = '{8'h08, 8'h14, 8'h00};

  operating_mode_controller #(.WARM_COUNT(8)) i_dut (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .clk_en       (clk_en),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_ack_o     (wb_ack_o),
    .wb_dat_o     (wb_dat_o),
    .irq_req      (irq_req),
    .tb_src       (tb_src),
    .halt_release (halt_release),
    .pwr          (pwr),
    .take_irq     (take_irq),
    .resume_next  (resume_next),
    .tbt_irq_set  (tbt_irq_set),
    .self_reset   (self_reset),
    .machine_tick (machine_tick)
  );

  always #2 core_clk = ~core_clk;

  // pulse counters
  always @(posedge core_clk) begin
    n_take <= n_take + int'(take_irq === 1'b1);
    n_res <= n_res + int'(resume_next === 1'b1);
    n_tbt <= n_tbt + int'(tbt_irq_set === 1'b1);
    n_rst <= n_rst + int'(self_reset === 1'b1);
    n_tick <= n_tick + int'(machine_tick === 1'b1);
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string s);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge core_clk);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e, "read");
  endtask

  task automatic st(input mode_t m);
    rdc(ADDR_STAT, 32'h0f, {28'h0, m});
  endtask

  task automatic wake();
    irq_req <= 1'b1;
    step(1);
    irq_req <= 1'b0;
    step(2);
  endtask

  task automatic tb_fall(input int b);
    tb_src[b] <= 1'b0;
    step(3);
    tb_src <= 8'hff;
    step(1);
  endtask

  initial begin
    #100000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    step(3);
    resetn <= 1'b1;
    step(1);
    st(run_fast_single);
    chk(pwr, 9'h13e, "reset pwr");
    rdc(ADDR_CTL_TWO, 32'h1f, {27'h0, C2_RST});
    rdc(8'h14, 32'hffffffff, 32'h0);
    t0 = n_tick;
    step(40);
    chk(n_tick - t0, 10, "ticks");
    $display("test reset done");

    wr(ADDR_IRQ, 8'h01);
    wr(ADDR_CTL_TWO, 8'h11);
    st(doze_fast_single);
    chk({pwr.cpu_run, pwr.wdt_run, pwr.periph_clk_on}, 1, "doze");
    t0 = n_tick;
    step(8);
    chk(n_tick - t0, 0, "doze ticks");
    wake();
    chk(n_take, 1, "take");
    st(run_fast_single);
    rdc(ADDR_CTL_TWO, 32'h1f, 32'h10);
    wr(ADDR_IRQ, 8'h00);
    wr(ADDR_CTL_TWO, 8'h11);
    wake();
    chk(n_take, 1, "resume take");
    chk(n_res, 1, "resume");
    $display("test doze done");

    wr(ADDR_TBC, 8'h0a);
    wr(ADDR_IRQ, 8'h03);
    wr(ADDR_CTL_TWO, 8'h12);
    st(deep_doze_fast);
    chk(pwr[6:1], 6'h03, "deep pwr");
    tb_fall(1);
    st(deep_doze_fast);
    tb_fall(2);
    st(run_fast_single);
    chk(n_take, 2, "deep irq");
    chk(n_tbt, 1, "deep latch");
    rdc(ADDR_CTL_TWO, 32'h1f, 32'h10);
    wr(ADDR_TBC, 8'h02);
    wr(ADDR_CTL_TWO, 8'h12);
    st(deep_doze_fast);
    tb_fall(2);
    st(run_fast_single);
    chk(n_res, 2, "deep no en");
    chk(n_tbt, 1, "deep no latch");
    $display("test deep done");

    wr(ADDR_CTL_TWO, 8'h18);
    st(run_fast_dual);
    chk({pwr.slow_pins_osc, pwr.main_clk_slow}, 2'h2, "dual");
    wr(ADDR_CTL_TWO, 8'h1c);
    st(run_slow_dual);
    chk({pwr.main_clk_slow, pwr.fast_osc_on}, 2'h3, "run_slow_dual");
    wr(ADDR_CTL_TWO, 8'h1d);
    st(doze_slow_dual);
    chk({pwr.fast_osc_on, pwr.cpu_run}, 2'h2, "doze_slow_dual");
    wake();
    st(run_slow_dual);
    wr(ADDR_CTL_TWO, 8'h1e);
    st(deep_doze_slow);
    tb_fall(2);
    st(run_slow_only);
    chk(n_take, 3, "slow wake take");
    chk(n_res, 3, "slow wake");
    rdc(ADDR_CTL_TWO, 32'h1f, 32'h0c);
    chk({pwr.fast_osc_on, pwr.div_low_on}, 2'h0, "run_slow_only");
    wr(ADDR_CTL_TWO, 8'h0d);
    st(doze_slow_only);
    chk(pwr[8:5], 4'h6, "doze_slow_only");
    wake();
    st(run_slow_only);
    wr(ADDR_CTL_TWO, 8'h1c);
    st(run_slow_dual);
    wr(ADDR_CTL_TWO, 8'h18);
    wr(ADDR_CTL_TWO, 8'h19);
    st(doze_fast_dual);
    chk({pwr.periph_clk_on, pwr.cpu_run}, 2'h2, "doze_fast_dual");
    wake();
    st(run_fast_dual);
    chk(n_take, 5, "doze_fast_dual take");
    $display("test dual done");

    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTL_TWO, pre_v[i]);
      wr(ADDR_CTL_TWO, bad_v[i]);
      step(2);
      chk(n_rst, i + 1, "self reset");
      st(run_fast_single);
      rdc(ADDR_CTL_TWO, 32'h1f, 32'h10);
    end
    $display("test illegal done");

    wr(ADDR_CTL_ONE, 8'h03);
    chk({pwr.fast_osc_on, pwr.cpu_run}, 2'h0, "osc off");
    halt_release <= 1'b1;
    step(4);
    chk(pwr.cpu_run, 0, "warm");
    step(12);
    chk(pwr.cpu_run, 1, "level run");
    chk(n_res, 4, "level resume");
    st(run_fast_single);
    rdc(ADDR_CTL_ONE, 32'h01, 32'h0);
    wr(ADDR_CTL_ONE, 8'h01);
    step(20);
    chk(pwr.cpu_run, 0, "edge hold");
    halt_release <= 1'b0;
    step(2);
    halt_release <= 1'b1;
    step(16);
    chk(pwr.cpu_run, 1, "edge run");
    chk(n_res, 5, "edge resume");
    $display("test halt done");
    results();
  end
endmodule
